//--- include/uams_defs.vh
`ifndef UAMS_DEFS_VH
`define UAMS_DEFS_VH

// Register indices on the three register-select lines
`define UAMS_IDX_DATA   3'h0
`define UAMS_IDX_IER    3'h1
`define UAMS_IDX_IIR    3'h2
`define UAMS_IDX_LCR    3'h3
`define UAMS_IDX_MCR    3'h4
`define UAMS_IDX_LSR    3'h5
`define UAMS_IDX_MSR    3'h6

// Field positions
`define UAMS_LCR_DIV    7
`define UAMS_LCR_PEN    3
`define UAMS_LCR_EPS    4
`define UAMS_LCR_STB    2
`define UAMS_MCR_LOOP   4
`define UAMS_MCR_OUT2   3
`define UAMS_IER_MODEM  3
`define UAMS_IER_THRE   1
`define UAMS_IER_RDA    0
`define UAMS_LSR_DR     0
`define UAMS_LSR_THRE   5
`define UAMS_LSR_TEMT   6

// Reset values, masks and interrupt identification codes
`define UAMS_MCR_MASK   8'h1F
`define UAMS_IER_MASK   8'h0F
`define UAMS_ZERO8      8'h00
`define UAMS_DIV_RST    8'h0C
`define UAMS_IIR_NONE   8'h01
`define UAMS_IIR_RDA    8'h04
`define UAMS_IIR_THRE   8'h02
`define UAMS_IIR_MODEM  8'h00

// Baud timing: sixteen ticks of the divided clock per bit
`define UAMS_OVERSAMPLE 4'hF
`define UAMS_HALF_BIT   4'h7
// Last tick of a long stop: one and a half bits, or two bits
`define UAMS_STOP_1P5   5'h17
`define UAMS_STOP_2     5'h1F

// Transmit states
`define UAMS_TX_IDLE    3'h0
`define UAMS_TX_START   3'h1
`define UAMS_TX_DATA    3'h2
`define UAMS_TX_PAR     3'h3
`define UAMS_TX_STOP    3'h4

`endif

//--- logic/uams_top.v
// Contract
// R1 - Wrap-mode writes to delta bits raise interrupt
// R2 - Host reprograms registers before clearing wrap
// R3 - Modem control top three bits read zero
// R4 - Delta bits set on change, clear on read
// R5 - Bits 0,1,3 flag CTS, DSR, carrier changes
// R6 - Bit 2 set on ringing trailing edge
// R7 - Any delta bit raises modem interrupt
// R8 - Bits 4-7 show inverted modem inputs
// R9 - Wrap mode mirrors modem control bits there
// R10 - First received bit lands in bit 0
// R11 - Transmit bit 0 goes out first
// R12 - System interrupt gated by aux output two
// R13 - Start, parity, stop bits added automatically
// R14 - Binary 1 is mark, 0 is space
// R15 - Selected when both highs high, low low
// R16 - Select and address latched by address strobe
// R17 - Either read strobe polarity reads register
// R18 - Either write strobe polarity writes register
// R19 - Host ties unused strobe companion inactive
// R20 - Host strobes address when lines unstable
// R21 - Divisor access bit extends register select
// R22 - Divisor access remaps offsets zero and one
// R23 - Wrap loops serial and modem lines internally
// R24 - Modem interrupt needs enable bit three
// R25 - Modem inputs synchronised before change detect
`timescale 1ns/1ns
`include "uams_defs.vh"

module uams_top (
    input  wire       mclk,
    input  wire       sys_rst,
    input  wire       chip_sel_hi_a,
    input  wire       chip_sel_hi_b,
    input  wire       chip_sel_low,
    input  wire       addr_latch_strobe_n,
    input  wire       reg_sel_bit0,
    input  wire       reg_sel_bit1,
    input  wire       reg_sel_bit2,
    input  wire       read_strobe_hi,
    input  wire       read_strobe_lo,
    input  wire       write_strobe_hi,
    input  wire       write_strobe_lo,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output wire       data_oe,
    output wire       chip_sel_out,
    output wire       drv_disable,
    input  wire       serial_in,
    output wire       serial_out,
    input  wire       clear_to_send_n,
    input  wire       set_ready_n,
    input  wire       phone_ringing_n,
    input  wire       carrier_detect_n,
    output wire       term_ready_n,
    output wire       req_to_send_n,
    output wire       aux_out1_n,
    output wire       aux_out2_n,
    output wire       chip_irq,
    output wire       sys_irq
);
    reg  [7:0] ier_q, lcr_q, mcr_q, div_lo_q, div_hi_q, rbr_q, thr_q;
    reg  [3:0] delta_q;
    reg  [3:0] msync1_q, msync2_q, mprev_q;
    reg        sin1_q, sin2_q;
    reg        cs_lat_q;
    reg  [2:0] addr_lat_q;
    reg        rd_prev_q, wr_prev_q;
    reg        thr_full_q, dr_q, thre_ack_q;
    reg  [15:0] baud_q;
    reg  [3:0] rx_tick_q;
    reg  [2:0] rx_bit_q;
    reg  [1:0] rx_st_q;
    reg  [7:0] rx_shift_q;
    wire       tx_busy;

    wire loop = mcr_q[`UAMS_MCR_LOOP];
    wire divisor_access_sel = lcr_q[`UAMS_LCR_DIV];

    // Chip select decode and address-strobe transparent latch
    wire cs_now = chip_sel_hi_a & chip_sel_hi_b & ~chip_sel_low; // see R15
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_lat_q   <= 1'b0;
            addr_lat_q <= 3'h0;
        end else if (!addr_latch_strobe_n) begin
            cs_lat_q   <= cs_now; // see R16
            addr_lat_q <= {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0};
        end
    end
    // Strobe held low: latch is transparent, follow the pins directly
    wire       sel  = addr_latch_strobe_n ? cs_lat_q : cs_now; // see R16
    wire [2:0] addr = addr_latch_strobe_n ? addr_lat_q : {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0};
    assign chip_sel_out = sel;

    // Either polarity counts; host keeps the unused one idle
    wire rd_lvl = sel & (read_strobe_hi | ~read_strobe_lo);   // see R17
    wire wr_lvl = sel & (write_strobe_hi | ~write_strobe_lo); // see R18
    wire rd_end = rd_prev_q & ~rd_lvl;
    wire wr_go  = wr_lvl & ~wr_prev_q;
    assign data_oe     = rd_lvl;
    assign drv_disable = ~rd_lvl;

    // Decode with divisor-access bit folded in
    function [3:0] reg_idx;
        input       dl;
        input [2:0] a;
        begin
            reg_idx = {dl & (a[2:1] == 2'b00), a}; // see R21
        end
    endfunction
    wire [3:0] ridx = reg_idx(divisor_access_sel, addr);
    wire rd_msr  = rd_end && ridx == {1'b0, `UAMS_IDX_MSR};
    wire rd_rbr  = rd_end && ridx == {1'b0, `UAMS_IDX_DATA};
    wire rd_iir  = rd_end && ridx == {1'b0, `UAMS_IDX_IIR};
    wire wr_thr  = wr_go && ridx == {1'b0, `UAMS_IDX_DATA};

    // Modem inputs: wrap feeds MODEM_CTRL_REG bits instead of pins
    wire [3:0] m_src = loop ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} // see R23
                            : {~carrier_detect_n, ~phone_ringing_n, ~set_ready_n, ~clear_to_send_n};
    // Two-flop sync, edge detect on the settled copy only
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            msync1_q <= 4'h0;
            msync2_q <= 4'h0;
            mprev_q  <= 4'h0;
        end else begin
            msync1_q <= m_src; // see R25
            msync2_q <= msync1_q;
            mprev_q  <= msync2_q;
        end
    end
    wire [3:0] chg = msync2_q ^ mprev_q;
    wire [3:0] delta_set = {chg[3], mprev_q[2] & ~msync2_q[2], chg[1], chg[0]}; // see R5 see R6

    // Status mirror: wrap shows MODEM_CTRL_REG bits directly
    wire [3:0] msr_hi = loop ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} : msync2_q; // see R8 see R9
    wire [7:0] modem_line_state = {msr_hi, delta_q};

    // Interrupt sources and priority (line status is not part of this block)
    wire thre_irq = ~thr_full_q & ~thre_ack_q;
    wire msi   = |delta_q; // see R7
    wire en_rd = ier_q[`UAMS_IER_RDA] & dr_q;
    wire en_th = ier_q[`UAMS_IER_THRE] & thre_irq;
    wire en_ms = ier_q[`UAMS_IER_MODEM] & msi; // see R24
    wire [7:0] iir = en_rd ? `UAMS_IIR_RDA : en_th ? `UAMS_IIR_THRE : en_ms ? `UAMS_IIR_MODEM : `UAMS_IIR_NONE;
    assign chip_irq = en_rd | en_th | en_ms;
    assign sys_irq  = chip_irq & mcr_q[`UAMS_MCR_OUT2]; // see R12

    // Register writes; hardware set of a delta bit beats read clear
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ier_q      <= `UAMS_ZERO8;
            lcr_q      <= `UAMS_ZERO8;
            mcr_q      <= `UAMS_ZERO8;
            div_lo_q   <= `UAMS_DIV_RST;
            div_hi_q   <= `UAMS_ZERO8;
            thr_q      <= `UAMS_ZERO8;
            delta_q    <= 4'h0;
            rd_prev_q  <= 1'b0;
            wr_prev_q  <= 1'b0;
            thre_ack_q <= 1'b0;
        end else begin
            rd_prev_q <= rd_lvl;
            wr_prev_q <= wr_lvl;
            delta_q   <= (rd_msr ? 4'h0 : delta_q) | delta_set; // see R4
            if (rd_iir && iir == `UAMS_IIR_THRE)
                thre_ack_q <= 1'b1;
            if (wr_go) begin
                case (ridx)
                    {1'b0, `UAMS_IDX_DATA}: begin
                        thr_q      <= data_in;
                        thre_ack_q <= 1'b0;
                    end
                    {1'b0, `UAMS_IDX_IER}: ier_q <= data_in & `UAMS_IER_MASK;
                    {1'b1, `UAMS_IDX_DATA}: div_lo_q <= data_in; // see R22
                    {1'b1, `UAMS_IDX_IER}:  div_hi_q <= data_in;
                    {1'b0, `UAMS_IDX_LCR}, {1'b1, `UAMS_IDX_LCR}: lcr_q <= data_in;
                    {1'b0, `UAMS_IDX_MCR}, {1'b1, `UAMS_IDX_MCR}: mcr_q <= data_in & `UAMS_MCR_MASK; // see R3
                    // Test path: in wrap a write may set delta bits
                    {1'b0, `UAMS_IDX_MSR}, {1'b1, `UAMS_IDX_MSR}:
                        if (loop) delta_q <= delta_q | data_in[3:0] | delta_set; // see R1
                    default: ;
                endcase
            end
        end
    end

    // Read data is reloaded from flops on every clock, whether or not the strobe is active
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            data_out <= `UAMS_ZERO8;
        end else begin
            case (ridx)
                {1'b0, `UAMS_IDX_DATA}: data_out <= rbr_q;
                {1'b0, `UAMS_IDX_IER}:  data_out <= ier_q;
                {1'b1, `UAMS_IDX_DATA}: data_out <= div_lo_q;
                {1'b1, `UAMS_IDX_IER}:  data_out <= div_hi_q;
                {1'b0, `UAMS_IDX_IIR}, {1'b1, `UAMS_IDX_IIR}: data_out <= iir;
                {1'b0, `UAMS_IDX_LCR}, {1'b1, `UAMS_IDX_LCR}: data_out <= lcr_q;
                {1'b0, `UAMS_IDX_MCR}, {1'b1, `UAMS_IDX_MCR}: data_out <= mcr_q & `UAMS_MCR_MASK; // see R3
                {1'b0, `UAMS_IDX_LSR}, {1'b1, `UAMS_IDX_LSR}:
                    data_out <= {1'b0, ~thr_full_q & ~tx_busy, ~thr_full_q, 4'h0, dr_q};
                {1'b0, `UAMS_IDX_MSR}, {1'b1, `UAMS_IDX_MSR}: data_out <= modem_line_state;
                default: data_out <= `UAMS_ZERO8;
            endcase
        end
    end

    // Baud divider: one enable pulse per sixteenth of a bit
    wire [15:0] divisor = {div_hi_q, div_lo_q};
    wire        tick    = (baud_q == 16'h0001) || (divisor <= 16'h0001);
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            baud_q <= 16'h0000;
        else if (baud_q <= 16'h0001)
            baud_q <= divisor;
        else
            baud_q <= baud_q - 16'h0001;
    end

    // Holding register hands one character to the shifter
    wire tx_line;
    wire tx_load = thr_full_q & ~tx_busy;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            thr_full_q <= 1'b0;
        else if (wr_thr)
            thr_full_q <= 1'b1;
        else if (tx_load)
            thr_full_q <= 1'b0;
    end

    uams_tx_shift u_tx (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .tick      (tick),
        .load      (tx_load),
        .char_in   (thr_q),
        .word_len  (lcr_q[1:0]),
        .par_en    (lcr_q[`UAMS_LCR_PEN]),
        .par_even  (lcr_q[`UAMS_LCR_EPS]),
        .stop_long (lcr_q[`UAMS_LCR_STB]),
        .busy      (tx_busy),
        .line_q    (tx_line)
    );
    // Wrap holds the pin at mark and loops the shifter inward
    assign serial_out = loop ? 1'b1 : tx_line; // see R23 see R14
    assign term_ready_n  = ~mcr_q[0];
    assign req_to_send_n = ~mcr_q[1];
    assign aux_out1_n    = ~mcr_q[2];
    assign aux_out2_n    = ~mcr_q[3];

    // Receiver: mid-bit sampling, no parity or framing checks here
    wire rx_pin = loop ? tx_line : sin2_q; // see R23
    wire [2:0] rx_last = {1'b1, lcr_q[1:0]};
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sin1_q     <= 1'b1;
            sin2_q     <= 1'b1;
            rx_st_q    <= 2'h0;
            rx_tick_q  <= 4'h0;
            rx_bit_q   <= 3'h0;
            rx_shift_q <= 8'h00;
            rbr_q      <= 8'h00;
            dr_q       <= 1'b0;
        end else begin
            sin1_q <= serial_in;
            sin2_q <= sin1_q;
            if (rd_rbr)
                dr_q <= 1'b0;
            if (tick) begin
                rx_tick_q <= rx_tick_q + 4'h1;
                case (rx_st_q)
                    2'h0: begin
                        rx_tick_q <= 4'h0;
                        if (!rx_pin) rx_st_q <= 2'h1;
                    end
                    2'h1: if (rx_tick_q == `UAMS_HALF_BIT) begin
                        rx_tick_q <= 4'h0;
                        rx_bit_q  <= 3'h0;
                        rx_st_q   <= rx_pin ? 2'h0 : 2'h2;
                    end
                    2'h2: if (rx_tick_q == `UAMS_OVERSAMPLE) begin
                        rx_shift_q <= {rx_pin, rx_shift_q[7:1]};
                        rx_bit_q   <= rx_bit_q + 3'h1;
                        if (rx_bit_q == rx_last) rx_st_q <= 2'h3;
                    end
                    2'h3: if (rx_tick_q == `UAMS_OVERSAMPLE) begin
                        // Right-justify so first bit sits in bit 0
                        rbr_q   <= rx_shift_q >> (3'h7 - rx_last); // see R10
                        dr_q    <= 1'b1;
                        rx_st_q <= 2'h0;
                    end
                    default: rx_st_q <= 2'h0;
                endcase
            end
        end
    end
endmodule // uams_top

//--- logic/uams_tx_shift.v
`timescale 1ns/1ns
`include "uams_defs.vh"

// Character serialiser: start, data LSB first, optional parity, stop bits
module uams_tx_shift (
    input  wire       mclk,
    input  wire       sys_rst,
    input  wire       tick,
    input  wire       load,
    input  wire [7:0] char_in,
    input  wire [1:0] word_len,
    input  wire       par_en,
    input  wire       par_even,
    input  wire       stop_long,
    output wire       busy,
    output reg        line_q
);
    reg [2:0] state_q;
    reg [7:0] shift_q;
    reg [2:0] bit_q;
    reg [4:0] tick_q;
    reg       par_q;
    wire [2:0] last_bit = {1'b1, word_len};
    // One and a half stop bits for five-bit words, else two
    wire [4:0] stop_ticks = (word_len == 2'h0) ? `UAMS_STOP_1P5 : `UAMS_STOP_2;
    // Long stop counts its own span; every other bit is sixteen ticks
    wire       long_stop  = (state_q == `UAMS_TX_STOP) && stop_long; // see R13
    wire       bit_more   = long_stop ? (tick_q != stop_ticks) : (tick_q[3:0] != `UAMS_OVERSAMPLE);

    assign busy = (state_q != `UAMS_TX_IDLE);

    // Bit sequencer; an idle line rests at mark (binary 1)
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= `UAMS_TX_IDLE;
            shift_q <= 8'h00;
            bit_q   <= 3'h0;
            tick_q  <= 5'h00;
            par_q   <= 1'b0;
            line_q  <= 1'b1; // see R14
        end else if (state_q == `UAMS_TX_IDLE) begin
            if (load) begin
                shift_q <= char_in;
                par_q   <= ~par_even;
                state_q <= `UAMS_TX_START;
                tick_q  <= 5'h00;
                line_q  <= 1'b0; // see R13
            end
        end else if (tick) begin
            if (bit_more) begin
                tick_q <= tick_q + 5'h01;
            end else begin
                tick_q <= 5'h00;
                case (state_q)
                    `UAMS_TX_START: begin
                        state_q <= `UAMS_TX_DATA;
                        bit_q   <= 3'h0;
                        line_q  <= shift_q[0]; // see R11
                        par_q   <= par_q ^ shift_q[0];
                    end
                    `UAMS_TX_DATA: begin
                        if (bit_q == last_bit) begin
                            state_q <= par_en ? `UAMS_TX_PAR : `UAMS_TX_STOP;
                            line_q  <= par_en ? par_q : 1'b1; // see R13
                        end else begin
                            bit_q   <= bit_q + 3'h1;
                            shift_q <= {1'b0, shift_q[7:1]};
                            line_q  <= shift_q[1];
                            par_q   <= par_q ^ shift_q[1];
                        end
                    end
                    `UAMS_TX_PAR: begin
                        state_q <= `UAMS_TX_STOP;
                        line_q  <= 1'b1;
                    end
                    `UAMS_TX_STOP: state_q <= `UAMS_TX_IDLE;
                    default: state_q <= `UAMS_TX_IDLE;
                endcase
            end
        end
    end
endmodule // uams_tx_shift

//--- test/uams_host_model.sv
`timescale 1ns/1ns
// Host processor on the register port
module uams_host_model (
    input  wire       mclk,
    input  wire [7:0] data_out,
    output reg        chip_sel_hi_a       = 1'b0,
    output reg        chip_sel_hi_b       = 1'b0,
    output reg        chip_sel_low        = 1'b1,
    output reg        addr_latch_strobe_n = 1'b1,
    output reg        reg_sel_bit0        = 1'b0,
    output reg        reg_sel_bit1        = 1'b0,
    output reg        reg_sel_bit2        = 1'b0,
    output reg        read_strobe_hi      = 1'b0,
    output reg        read_strobe_lo      = 1'b1,
    output reg        write_strobe_hi     = 1'b0,
    output reg        write_strobe_lo     = 1'b1,
    output reg  [7:0] data_in             = 8'h00
);
    reg [2:0] cs_pat = 3'b110; // {hi_a, hi_b, low} put out during an access
    reg       use_lo = 1'b0;   // Low-active strobe of each pair in use

    // One access; released lines are scrambled so only the latch can hold them
    task access(input wr, input [2:0] a, input [7:0] d, output [7:0] q);
        begin
            @(negedge mclk);
            {chip_sel_hi_a, chip_sel_hi_b, chip_sel_low} = cs_pat;
            {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = a;
            data_in = d;
            addr_latch_strobe_n = 1'b0;
            @(negedge mclk);
            if (wr) begin
                {write_strobe_hi, write_strobe_lo} = use_lo ? 2'b00 : 2'b11;
            end else begin
                {read_strobe_hi, read_strobe_lo} = use_lo ? 2'b00 : 2'b11;
            end
            repeat (2) @(negedge mclk);
            q = data_out;
            {write_strobe_hi, write_strobe_lo, read_strobe_hi, read_strobe_lo} = 4'h5;
            addr_latch_strobe_n = 1'b1;
            @(negedge mclk);
            {chip_sel_hi_a, chip_sel_hi_b, chip_sel_low} = 3'b001;
            {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = ~a;
            data_in = ~d;
        end
    endtask
endmodule // uams_host_model

//--- test/uams_top_asserts.sv
`timescale 1ns/1ns
// Port-level checks: register port decode, bus turn, interrupt gate, serial line
module uams_top_asserts (
    input wire mclk,
    input wire sys_rst,
    input wire chip_sel_hi_a,
    input wire chip_sel_hi_b,
    input wire chip_sel_low,
    input wire addr_latch_strobe_n,
    input wire read_strobe_hi,
    input wire read_strobe_lo,
    input wire write_strobe_hi,
    input wire write_strobe_lo,
    input wire data_oe,
    input wire drv_disable,
    input wire chip_sel_out,
    input wire serial_out,
    input wire term_ready_n,
    input wire req_to_send_n,
    input wire aux_out1_n,
    input wire aux_out2_n,
    input wire chip_irq,
    input wire sys_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Decode is judged only once the strobe has held steady pins for a cycle
    chk_sel_decode: assert property (
        !addr_latch_strobe_n && $past(!addr_latch_strobe_n) && $stable({chip_sel_hi_a, chip_sel_hi_b, chip_sel_low})
        |-> chip_sel_out == (chip_sel_hi_a && !chip_sel_low && chip_sel_hi_b)) else $error("chip select decode wrong");
    chk_read_drive: assert property (
        data_oe == (chip_sel_out && (read_strobe_hi || !read_strobe_lo))) else $error("bus drive not tied to read");
    chk_write_quiet: assert property (
        (write_strobe_hi || !write_strobe_lo) && !read_strobe_hi && read_strobe_lo
        |-> drv_disable && !data_oe) else $error("bus turned during write");
    chk_sys_gate: assert property (
        sys_irq == (chip_irq && !aux_out2_n)) else $error("system request not gated by aux two");
    chk_start_len: assert property (
        $fell(serial_out) |-> !serial_out [*8]) else $error("spacing bit too short");
    chk_reset_idle: assert property (
        $fell(sys_rst) |-> serial_out && aux_out2_n && term_ready_n && !sys_irq) else $error("reset state wrong");
    chk_ctrl_by_write: assert property (
        $changed({term_ready_n, req_to_send_n, aux_out1_n, aux_out2_n})
        |-> $past(chip_sel_out && (write_strobe_hi || !write_strobe_lo))) else $error("modem output moved w/o write");
    chk_oe_turn: assert property (
        $rose(data_oe) |-> !drv_disable ##1 (drv_disable != data_oe)) else $error("driver disable not inverse");
endmodule // uams_top_asserts

bind uams_top uams_top_asserts u_chk (.*);

//--- test/uart_modem_status_and_host_port_tb_top.sv
`timescale 1ns/1ns
`include "uams_defs.vh"

module uart_modem_status_and_host_port_tb_top;
    reg         mclk    = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [3:0]  pins    = 4'hF; // {carrier, ringing, set ready, clear to send}, low active
    wire        carrier_detect_n = pins[3], phone_ringing_n = pins[2], set_ready_n = pins[1], clear_to_send_n = pins[0];
    wire        chip_sel_hi_a, chip_sel_hi_b, chip_sel_low, addr_latch_strobe_n, reg_sel_bit0, reg_sel_bit1;
    wire        reg_sel_bit2, read_strobe_hi, read_strobe_lo, write_strobe_hi, write_strobe_lo;
    wire [7:0]  data_in, data_out;
    wire        data_oe, chip_sel_out, drv_disable, serial_in, serial_out, chip_irq, sys_irq;
    wire        term_ready_n, req_to_send_n, aux_out1_n, aux_out2_n;
    integer     n_fail = 0, checked = 0, cyc = 0, i, k;
    reg  [31:0] seed = 32'h0001024C;
    reg  [7:0]  q, e, scratch;
    reg  [3:0]  old;
    reg  [10:0] frame;

    uams_top u_dut (.*);
    uams_host_model u_host (.*);

    // Far end echoes the line, so frames we send come back to the receiver
    assign serial_in = serial_out;

    // Clock, and a cycle ceiling that cuts a hang short
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            n_fail = n_fail + 1;
            print_verdict;
        end
    end

    function [31:0] next_rnd(input [31:0] s);
        next_rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Status byte expected after pins move from was to now
    function [7:0] msr_exp(input [3:0] was, input [3:0] now);
        msr_exp = {~now, was[3] ^ now[3], ~was[2] & now[2], was[1:0] ^ now[1:0]};
    endfunction

    task chk(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task wr(input [2:0] a, input [7:0] d);
        u_host.access(1'b1, a, d, scratch);
    endtask

    task rd(input [2:0] a, output [7:0] d);
        u_host.access(1'b0, a, 8'h00, d);
    endtask

    task print_verdict;
        begin
            if (n_fail == 0 && checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // Main sequence
    initial begin
        repeat (8) @(negedge mclk);
        sys_rst = 1'b0;
        rd(`UAMS_IDX_MSR, q);
        rd(3'h7, q);
        chk(q, 8'h00);
        // Normal mode: random pin moves, enables and strobe polarity
        for (i = 0; i < 14; i = i + 1) begin
            seed = next_rnd(seed);
            u_host.use_lo = seed[8];
            wr(`UAMS_IDX_IER, {4'hF, seed[13], 3'h0});
            wr(`UAMS_IDX_MCR, {seed[7:5], 1'b0, seed[3:0]});
            rd(`UAMS_IDX_MCR, q);
            chk(q, {4'h0, seed[3:0]});
            chk({4'h0, aux_out2_n, aux_out1_n, req_to_send_n, term_ready_n}, {4'h0, ~seed[3:0]});
            old = pins;
            pins = seed[12:9];
            repeat (4) @(negedge mclk);
            e = msr_exp(old, pins);
            chk({sys_irq, chip_irq}, {seed[3], 1'b1} & {2{seed[13] & (|e[3:0])}});
            rd(`UAMS_IDX_MSR, q);
            chk(q, e);
            rd(`UAMS_IDX_MSR, q);
            chk(q, {e[7:4], 4'h0});
        end
        // Wrap mode: pins ignored, control bits mirrored, written deltas raise the request
        wr(`UAMS_IDX_IER, 8'h08);
        for (i = 0; i < 4; i = i + 1) begin
            seed = next_rnd(seed);
            wr(`UAMS_IDX_MCR, {4'h1, seed[3:0]});
            pins = seed[12:9];
            rd(`UAMS_IDX_MSR, q);
            rd(`UAMS_IDX_MSR, q);
            chk(q, {seed[3:2], seed[0], seed[1], 4'h0});
            chk({7'h00, serial_out}, 8'h01);
            wr(`UAMS_IDX_MSR, {4'h0, seed[7:4] | 4'h1});
            chk({sys_irq, chip_irq}, {seed[3], 1'b1});
            rd(`UAMS_IDX_MSR, q);
            chk(q, {seed[3:2], seed[0], seed[1], seed[7:4] | 4'h1});
            rd(`UAMS_IDX_MSR, q);
            chk({7'h00, chip_irq}, 8'h00);
        end
        wr(`UAMS_IDX_MCR, 8'h00);
        rd(`UAMS_IDX_MSR, q);
        // Each half-wrong chip select must leave the register alone
        for (i = 0; i < 3; i = i + 1) begin
            u_host.cs_pat = (i == 0) ? 3'b010 : (i == 1) ? 3'b100 : 3'b111;
            wr(`UAMS_IDX_MCR, 8'h0F);
            u_host.cs_pat = 3'b110;
            rd(`UAMS_IDX_MCR, q);
            chk(q, 8'h00);
        end
        // Divisor bytes share offsets 0 and 1; divisor 1 keeps frames short
        seed = next_rnd(seed);
        wr(`UAMS_IDX_LCR, 8'h80);
        wr(`UAMS_IDX_IER, seed[7:0]);
        wr(`UAMS_IDX_DATA, 8'h01);
        rd(`UAMS_IDX_IER, q);
        chk(q, seed[7:0]);
        wr(`UAMS_IDX_IER, 8'h00);
        rd(`UAMS_IDX_DATA, q);
        chk(q, 8'h01);
        wr(`UAMS_IDX_LCR, 8'h03);
        rd(`UAMS_IDX_IER, q);
        chk(q, 8'h08);
        // Frames sampled mid-bit at sixteen cycles a bit, then read back
        for (i = 0; i < 2; i = i + 1) begin
            seed = next_rnd(seed);
            wr(`UAMS_IDX_LCR, {3'h0, seed[8], i[0], 3'h3});
            wr(`UAMS_IDX_DATA, seed[7:0]);
            for (k = 0; k < 400 && serial_out !== 1'b0; k = k + 1)
                @(negedge mclk);
            repeat (6) @(negedge mclk);
            for (k = 0; k < 11; k = k + 1) begin
                frame[k] = serial_out;
                repeat (16) @(negedge mclk);
            end
            chk(frame[8:1], seed[7:0]);
            chk({frame[10:9], frame[0]}, {1'b1, i[0] ? ~(seed[8] ^ ^seed[7:0]) : 1'b1, 1'b0});
            rd(`UAMS_IDX_DATA, q);
            chk(q, seed[7:0]);
        end
        print_verdict;
    end
endmodule // uart_modem_status_and_host_port_tb_top
